//--- verilog/srtc_map.vh
// Register offsets, field positions, reset values and timing constants.
`ifndef SRTC_MAP_VH
`define SRTC_MAP_VH

`define SRTC_A_SEC 4'h0
`define SRTC_A_MIN 4'h1
`define SRTC_A_HOUR 4'h2
`define SRTC_A_WDAY 4'h3
`define SRTC_A_DAY 4'h4
`define SRTC_A_MON 4'h5
`define SRTC_A_YEAR 4'h6
`define SRTC_A_ADJ 4'h7
`define SRTC_A_WA_MIN 4'h8
`define SRTC_A_WA_HOUR 4'h9
`define SRTC_A_WA_DAYS 4'ha
`define SRTC_A_DA_MIN 4'hb
`define SRTC_A_DA_HOUR 4'hc
`define SRTC_A_CTRL1 4'he
`define SRTC_A_CTRL2 4'hf

`define SRTC_C1_WA_EN 7
`define SRTC_C1_DA_EN 6
`define SRTC_C1_H24 5
`define SRTC_C1_CLK_OFF 4
`define SRTC_C1_PER_HALT 3
`define SRTC_C2_VD_SEL 6
`define SRTC_C2_VD_FLAG 5
`define SRTC_C2_PON 4
`define SRTC_C2_XST 3
`define SRTC_C2_PER_FLAG 2
`define SRTC_C2_WA_FLAG 1
`define SRTC_C2_DA_FLAG 0

`define SRTC_CTRL1_RST 8'h20
`define SRTC_DAY_RST 8'h01
`define SRTC_MON_RST 5'h01

`define SRTC_DIV_LAST 16'h7fff
`define SRTC_DIV_HALF 16'h3fff
`define SRTC_CLK_MHZ 20
`define SRTC_OSC_HALT_US 100
`define SRTC_DEV_ADDR 7'h32

`endif

//--- verilog/srtc_top.v
// Real-time clock and calendar with alarms, serial and parallel access.
`timescale 1ns/100ps
`include "srtc_map.vh"

module srtc_top
#(
  parameter [6:0] DEV_ADDR = `SRTC_DEV_ADDR
)
(
  input wire ref_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  input wire ser_clk_i,
  input wire ser_data_i,
  output wire ser_data_o,
  output wire ser_data_oe_o,
  input wire crystal_in_i,
  output wire crystal_out_o,
  input wire sub_clock_gate_in_i,
  output wire sub_clock_out_o,
  input wire supply_below_high_i,
  input wire supply_below_low_i,
  output wire irq_out_daily_periodic_o,
  output wire irq_out_daily_periodic_oe_o,
  output wire irq_out_weekly_o,
  output wire irq_out_weekly_oe_o
);

  localparam integer HALT_CYC_I = `SRTC_OSC_HALT_US * `SRTC_CLK_MHZ;
  localparam [11:0] HALT_CYC = HALT_CYC_I[11:0];
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_DEV = 3'd1;
  localparam [2:0] S_PTR = 3'd2;
  localparam [2:0] S_WR = 3'd3;
  localparam [2:0] S_RD = 3'd4;
  localparam [2:0] S_SKIP = 3'd5;

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last day of the month; years are 2000 to 2099, so every fourth is leap.
  function [7:0] last_day;
    input [4:0] m;
    input [7:0] y;
    reg leap;
    begin
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      if (m == 5'h02)
        last_day = leap ? 8'h29 : 8'h28;
      else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
        last_day = 8'h30;
      else
        last_day = 8'h31;
    end
  endfunction

  reg [7:0] sec_reg, min_reg, hour_reg, day_reg, year_reg;
  reg [2:0] wday_reg;
  reg [4:0] mon_reg;
  reg [6:0] adj_reg;
  reg [7:0] wa_min_reg, wa_hour_reg, da_min_reg, da_hour_reg;
  reg [6:0] wa_days_reg;
  reg [7:0] ctrl1_reg;
  reg vd_sel_reg, vd_flag_reg, pon_reg, xst_reg;
  reg per_flag_reg, wa_flag_reg, da_flag_reg;
  reg [7:0] rdata_reg;
  reg osc_s1, osc_s2, osc_s3;
  reg gate_s1, gate_s2, vh_s1, vh_s2, vl_s1, vl_s2;
  reg scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  reg [15:0] div_reg;
  reg [11:0] halt_cnt_reg;
  reg min_evt_reg;
  reg crystal_out_reg, sub_clk_reg, irq_a_reg, irq_b_reg;
  reg [2:0] st_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [3:0] ptr_reg;
  reg sda_oe_reg;
  reg i2c_wr;

  wire osc_rise = osc_s2 & ~osc_s3;
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_c = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  wire stop_c = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
  wire [7:0] byte_in = {shift_reg[6:0], sda_s2};

  // Parallel port writes win over a serial write in the same cycle.
  wire wr_en = wr_i | i2c_wr;
  wire [3:0] wa = wr_i ? addr_i : ptr_reg;
  wire [7:0] wd = wr_i ? wdata_i : shift_reg;

  function [7:0] reg_read;
    input [3:0] a;
    begin
      if (a == `SRTC_A_SEC) reg_read = sec_reg;
      else if (a == `SRTC_A_MIN) reg_read = min_reg;
      else if (a == `SRTC_A_HOUR) reg_read = hour_reg;
      else if (a == `SRTC_A_WDAY) reg_read = {5'h00, wday_reg};
      else if (a == `SRTC_A_DAY) reg_read = day_reg;
      else if (a == `SRTC_A_MON) reg_read = {3'h0, mon_reg};
      else if (a == `SRTC_A_YEAR) reg_read = year_reg;
      else if (a == `SRTC_A_ADJ) reg_read = {1'b0, adj_reg};
      else if (a == `SRTC_A_WA_MIN) reg_read = wa_min_reg;
      else if (a == `SRTC_A_WA_HOUR) reg_read = wa_hour_reg;
      else if (a == `SRTC_A_WA_DAYS) reg_read = {1'b0, wa_days_reg};
      else if (a == `SRTC_A_DA_MIN) reg_read = da_min_reg;
      else if (a == `SRTC_A_DA_HOUR) reg_read = da_hour_reg;
      else if (a == `SRTC_A_CTRL1) reg_read = ctrl1_reg;
      else if (a == `SRTC_A_CTRL2)
        reg_read = {1'b0, vd_sel_reg, vd_flag_reg, pon_reg, xst_reg,
                    per_flag_reg, wa_flag_reg, da_flag_reg};
      else reg_read = 8'h00;
    end
  endfunction

  // Synchronisers for the serial, gate and supply pin inputs and the crystal clock; the parallel port is not synchronised.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {osc_s1, osc_s2, osc_s3} <= 3'h0;
      {gate_s1, gate_s2, vh_s1, vh_s2, vl_s1, vl_s2} <= 6'h00;
      {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
    end
    else
    begin
      osc_s1 <= crystal_in_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      gate_s1 <= sub_clock_gate_in_i;
      gate_s2 <= gate_s1;
      vh_s1 <= supply_below_high_i;
      vh_s2 <= vh_s1;
      vl_s1 <= supply_below_low_i;
      vl_s2 <= vl_s1;
      scl_s1 <= ser_clk_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= ser_data_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // Rate trim: once every ten seconds the second is shortened or stretched.
  // adjusted divider end
  wire adj_now = (sec_reg[3:0] == 4'h0) && (adj_reg[5:0] != 6'h00);
  wire [15:0] adj_mag = {10'h000, adj_reg[5:0]};
  wire [15:0] div_term = !adj_now ? `SRTC_DIV_LAST :
    (adj_reg[6] ? `SRTC_DIV_LAST + adj_mag : `SRTC_DIV_LAST - adj_mag);
  wire sec_tick = osc_rise && (div_reg == div_term);
  wire half_tick = osc_rise && (div_reg == `SRTC_DIV_HALF);

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_reg <= 16'h0000;
    else if (wr_en && wa == `SRTC_A_SEC)
      div_reg <= 16'h0000;
    else if (sec_tick)
      div_reg <= 16'h0000;
    else if (osc_rise)
      div_reg <= div_reg + 16'h0001;
  end

  wire h24 = ctrl1_reg[`SRTC_C1_H24];
  wire sec_wrap = sec_reg == 8'h59;
  wire min_wrap = min_reg == 8'h59;
  wire hour_wrap = h24 ? (hour_reg == 8'h23)
                       : (hour_reg[5] && hour_reg[4:0] == 5'h11);
  wire day_wrap = day_reg == last_day(mon_reg, year_reg);
  wire mon_wrap = mon_reg == 5'h12;
  wire c_min = sec_tick & sec_wrap;
  wire c_hour = c_min & min_wrap;
  wire c_day = c_hour & hour_wrap;
  wire c_mon = c_day & day_wrap;
  wire c_year = c_mon & mon_wrap;

  wire [7:0] hour_lo_inc = bcd_inc({3'h0, hour_reg[4:0]});
  wire [7:0] mon_inc = bcd_inc({3'h0, mon_reg});

  reg [7:0] hour_next;
  always @*
  begin
    if (h24)
      hour_next = hour_wrap ? 8'h00 : bcd_inc(hour_reg);
    else if (hour_reg[4:0] == 5'h12)
      hour_next = {2'b00, hour_reg[5], 5'h01};
    else if (hour_reg[4:0] == 5'h11)
      hour_next = {2'b00, ~hour_reg[5], 5'h12};
    else
      hour_next = {2'b00, hour_reg[5], hour_lo_inc[4:0]};
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sec_reg <= 8'h00;
      min_reg <= 8'h00;
      hour_reg <= 8'h00;
      wday_reg <= 3'h0;
      day_reg <= `SRTC_DAY_RST;
      mon_reg <= `SRTC_MON_RST;
      year_reg <= 8'h00;
    end
    else
    begin
      if (wr_en && wa == `SRTC_A_SEC)
        sec_reg <= {1'b0, wd[6:0]};
      else if (sec_tick)
        sec_reg <= sec_wrap ? 8'h00 : bcd_inc(sec_reg);
      if (wr_en && wa == `SRTC_A_MIN)
        min_reg <= {1'b0, wd[6:0]};
      else if (c_min)
        min_reg <= min_wrap ? 8'h00 : bcd_inc(min_reg);
      if (wr_en && wa == `SRTC_A_HOUR)
        hour_reg <= {2'b00, wd[5:0]};
      else if (c_hour)
        hour_reg <= hour_next;
      if (wr_en && wa == `SRTC_A_WDAY)
        wday_reg <= wd[2:0];
      else if (c_day)
        wday_reg <= (wday_reg == 3'h6) ? 3'h0 : wday_reg + 3'h1;
      if (wr_en && wa == `SRTC_A_DAY)
        day_reg <= {2'b00, wd[5:0]};
      else if (c_day)
        day_reg <= day_wrap ? 8'h01 : bcd_inc(day_reg);
      if (wr_en && wa == `SRTC_A_MON)
        mon_reg <= wd[4:0];
      else if (c_mon)
        mon_reg <= mon_wrap ? 5'h01 : mon_inc[4:0];
      if (wr_en && wa == `SRTC_A_YEAR)
        year_reg <= wd;
      else if (c_year)
        year_reg <= (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
    end
  end

  // Configuration registers.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      adj_reg <= 7'h00;
      wa_min_reg <= 8'h00;
      wa_hour_reg <= 8'h00;
      wa_days_reg <= 7'h00;
      da_min_reg <= 8'h00;
      da_hour_reg <= 8'h00;
      ctrl1_reg <= `SRTC_CTRL1_RST;
      vd_sel_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      if (wa == `SRTC_A_ADJ) adj_reg <= wd[6:0];
      else if (wa == `SRTC_A_WA_MIN) wa_min_reg <= wd;
      else if (wa == `SRTC_A_WA_HOUR) wa_hour_reg <= wd;
      else if (wa == `SRTC_A_WA_DAYS) wa_days_reg <= wd[6:0];
      else if (wa == `SRTC_A_DA_MIN) da_min_reg <= wd;
      else if (wa == `SRTC_A_DA_HOUR) da_hour_reg <= wd;
      else if (wa == `SRTC_A_CTRL1) ctrl1_reg <= wd;
      else if (wa == `SRTC_A_CTRL2) vd_sel_reg <= wd[`SRTC_C2_VD_SEL];
    end
  end

  reg per_evt;
  always @*
  begin
    case (ctrl1_reg[2:0])
      3'd1: per_evt = half_tick | sec_tick;
      3'd2: per_evt = sec_tick;
      3'd3: per_evt = c_min;
      3'd4: per_evt = c_hour;
      3'd5: per_evt = c_day;
      3'd6: per_evt = c_mon;
      default: per_evt = 1'b0;
    endcase
  end

  // alarm compare at each new minute
  wire wa_match = min_evt_reg && wa_days_reg[wday_reg] &&
    wa_min_reg == min_reg && wa_hour_reg == hour_reg;
  wire da_match = min_evt_reg &&
    da_min_reg == min_reg && da_hour_reg == hour_reg;
  wire vd_evt = vd_sel_reg ? vh_s2 : vl_s2;
  // no crystal edge for too long
  wire xst_evt = halt_cnt_reg == HALT_CYC;
  wire c2_wr = wr_en && wa == `SRTC_A_CTRL2;

  function flag_next;
    input f;
    input clr_bit;
    input evt;
    begin
      flag_next = evt | (f & ~(c2_wr & ~clr_bit));
    end
  endfunction

  // Sticky status flags; an event in the clearing cycle wins.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pon_reg <= 1'b1;
      xst_reg <= 1'b0;
      vd_flag_reg <= 1'b0;
      per_flag_reg <= 1'b0;
      wa_flag_reg <= 1'b0;
      da_flag_reg <= 1'b0;
      halt_cnt_reg <= 12'h000;
      min_evt_reg <= 1'b0;
    end
    else
    begin
      pon_reg <= flag_next(pon_reg, wd[`SRTC_C2_PON], 1'b0);
      xst_reg <= flag_next(xst_reg, wd[`SRTC_C2_XST], xst_evt);
      vd_flag_reg <= flag_next(vd_flag_reg, wd[`SRTC_C2_VD_FLAG], vd_evt);
      per_flag_reg <= flag_next(per_flag_reg, wd[`SRTC_C2_PER_FLAG], per_evt);
      wa_flag_reg <= flag_next(wa_flag_reg, wd[`SRTC_C2_WA_FLAG], wa_match);
      da_flag_reg <= flag_next(da_flag_reg, wd[`SRTC_C2_DA_FLAG], da_match);
      if (osc_rise || xst_evt)
        halt_cnt_reg <= 12'h000;
      else
        halt_cnt_reg <= halt_cnt_reg + 12'h001;
      min_evt_reg <= c_min;
    end
  end

  // Pin drivers.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      crystal_out_reg <= 1'b0;
      sub_clk_reg <= 1'b0;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      crystal_out_reg <= ~osc_s2;
      sub_clk_reg <= osc_s2 & gate_s2 & ~ctrl1_reg[`SRTC_C1_CLK_OFF];
      irq_a_reg <= (da_flag_reg & ctrl1_reg[`SRTC_C1_DA_EN]) |
        (per_flag_reg & ~ctrl1_reg[`SRTC_C1_PER_HALT]);
      irq_b_reg <= wa_flag_reg & ctrl1_reg[`SRTC_C1_WA_EN];
      if (rd_i)
        rdata_reg <= reg_read(addr_i);
    end
  end

  // Two-wire serial slave; pointer auto-increments after each byte read, not after a written byte.
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg <= S_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      i2c_wr <= 1'b0;
    end
    else
    begin
      i2c_wr <= 1'b0;
      if (start_c)
      begin
        st_reg <= S_DEV;
        bit_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end
      else if (stop_c)
      begin
        st_reg <= S_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (st_reg != S_IDLE && st_reg != S_SKIP)
      begin
        // A high line on the ninth read clock is a master nack.
        if (scl_rise && st_reg == S_RD && bit_reg == 4'h8 && sda_s2)
          st_reg <= S_SKIP;
        else if (scl_rise && bit_reg != 4'h9)
        begin
          if (st_reg != S_RD)
            shift_reg <= byte_in;
          bit_reg <= bit_reg + 4'h1;
        end
        else if (scl_fall && bit_reg == 4'h8)
        begin
          case (st_reg)
            S_DEV:
            begin
              sda_oe_reg <= shift_reg[7:1] == DEV_ADDR;
              if (shift_reg[7:1] != DEV_ADDR)
                st_reg <= S_SKIP;
              else
                st_reg <= shift_reg[0] ? S_RD : S_PTR;
            end
            S_PTR:
            begin
              ptr_reg <= shift_reg[3:0];
              sda_oe_reg <= 1'b1;
              st_reg <= S_WR;
            end
            S_WR:
            begin
              i2c_wr <= 1'b1;
              sda_oe_reg <= 1'b1;
            end
            default:
            begin
              sda_oe_reg <= 1'b0;
              ptr_reg <= ptr_reg + 4'h1;
            end
          endcase
        end
        else if (scl_fall && bit_reg == 4'h9)
        begin
          bit_reg <= 4'h0;
          if (st_reg == S_RD)
          begin
            shift_reg <= reg_read(ptr_reg);
            sda_oe_reg <= ~(|(reg_read(ptr_reg) & 8'h80));
          end
          else
            sda_oe_reg <= 1'b0;
        end
        else if (scl_fall && st_reg == S_RD)
          sda_oe_reg <= ~shift_reg[3'h7 - bit_reg[2:0]];
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign ser_data_o = 1'b0;
  assign ser_data_oe_o = sda_oe_reg;
  assign sub_clock_out_o = sub_clk_reg;
  assign crystal_out_o = crystal_out_reg;
  assign irq_out_daily_periodic_o = 1'b0;
  assign irq_out_daily_periodic_oe_o = irq_a_reg;
  assign irq_out_weekly_o = 1'b0;
  assign irq_out_weekly_oe_o = irq_b_reg;

endmodule

//--- verification/srtc_chk_sva.sv
// Checker for the pin-level behaviour of the real-time clock block.
`timescale 1ns/100ps
module srtc_chk (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire crystal_in_i,
  input wire crystal_out_o,
  input wire sub_clock_gate_in_i,
  input wire sub_clock_out_o,
  input wire ser_data_o,
  input wire irq_out_daily_periodic_o,
  input wire irq_out_daily_periodic_oe_o,
  input wire irq_out_weekly_o,
  input wire irq_out_weekly_oe_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_PINA_LOW:
    assert property (irq_out_daily_periodic_o == 1'b0)
    else $error("first interrupt pin drives high");
  AST_PINB_LOW:
    assert property (irq_out_weekly_o == 1'b0)
    else $error("second interrupt pin drives high");
  AST_SDA_LOW:
    assert property (ser_data_o == 1'b0)
    else $error("serial data pin drives high");
  AST_IRQ_COLD:
    assert property ($fell(rst_i) |->
      !irq_out_daily_periodic_oe_o && !irq_out_weekly_oe_o)
    else $error("interrupt pin active right after reset");
  AST_GATE_OFF:
    assert property (!sub_clock_gate_in_i [*5] |-> !sub_clock_out_o)
    else $error("clock output runs with gate low");
  AST_REG_OFF:
    assert property (wr_i && addr_i == 4'he && wdata_i[4] |->
      ##2 (!sub_clock_out_o) [*4])
    else $error("clock output runs while disabled");
  AST_CLEAR_A:
    assert property (wr_i && addr_i == 4'hf && !wdata_i[0] && !wdata_i[2]
      |-> ##[1:2] !irq_out_daily_periodic_oe_o)
    else $error("first interrupt stays after clear");
  AST_CLEAR_B:
    assert property (wr_i && addr_i == 4'hf && !wdata_i[1] |->
      ##[1:2] !irq_out_weekly_oe_o)
    else $error("second interrupt stays after clear");
  AST_XTAL_INV:
    assert property ($stable(crystal_in_i) [*5] |->
      crystal_out_o != crystal_in_i)
    else $error("crystal output not inverted");
endmodule

bind srtc_top srtc_chk u_srtc_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .crystal_in_i(crystal_in_i),
  .crystal_out_o(crystal_out_o),
  .sub_clock_gate_in_i(sub_clock_gate_in_i),
  .sub_clock_out_o(sub_clock_out_o),
  .ser_data_o(ser_data_o),
  .irq_out_daily_periodic_o(irq_out_daily_periodic_o),
  .irq_out_daily_periodic_oe_o(irq_out_daily_periodic_oe_o),
  .irq_out_weekly_o(irq_out_weekly_o),
  .irq_out_weekly_oe_o(irq_out_weekly_oe_o)
);

//--- verification/srtc_host_model.sv
// Host model that runs frames on the two-wire serial link.
`timescale 1ns/100ps
module srtc_host_model (
  input wire logic line_i,
  output logic scl_o,
  output logic pull_low_o
);
  initial
  begin
    scl_o = 1'b1;
    pull_low_o = 1'b0;
  end

  // open drain, data moved only while the clock is low.
  task automatic bit_xfer(input logic b, output logic s);
    scl_o = 1'b0;
    #100 pull_low_o = ~b;
    #100 scl_o = 1'b1;
    #150 s = line_i;
    #50;
  endtask

  task automatic start;
    scl_o = 1'b0;
    #100 pull_low_o = 1'b0;
    #100 scl_o = 1'b1;
    #100 pull_low_o = 1'b1;
    #100;
  endtask

  task automatic stop;
    scl_o = 1'b0;
    #100 pull_low_o = 1'b1;
    #100 scl_o = 1'b1;
    #100 pull_low_o = 1'b0;
    #100;
  endtask

  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask

  task automatic byte_in(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, b[i]);
    bit_xfer(last, s);
  endtask

  task automatic wr_frame(input logic [6:0] dev, input logic [3:0] ptr,
    input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start;
    byte_out({dev, 1'b0}, a0);
    byte_out({4'h0, ptr}, a1);
    byte_out(d, a2);
    stop;
    ok = a0 & a1 & a2;
  endtask

  task automatic rd_frame(input logic [6:0] dev, input logic [3:0] ptr,
    output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start;
    byte_out({dev, 1'b0}, a0);
    byte_out({4'h0, ptr}, a1);
    start;
    byte_out({dev, 1'b1}, a2);
    byte_in(1'b1, d);
    stop;
    ok = a0 & a1 & a2;
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the real-time clock block.
`timescale 1ns/100ps
module tb_top;
  localparam logic [6:0] DEV = 7'h32;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic xtal = 1'b0;
  logic xtal_run = 1'b0;
  logic gate = 1'b0;
  logic sup_hi = 1'b0;
  logic sup_lo = 1'b0;
  wire [7:0] rdata_o;
  wire scl, host_low, sda_oe, sda_line, irq_a, irq_b, sub_clk;
  int err_count = 0;
  int num_checks = 0;
  int n;
  logic [7:0] rv;
  logic ok;
  logic [11:0] rst_tab [5] = '{12'h000, 12'h401, 12'h501, 12'he20, 12'hd00};
  logic [11:0] set_tab [14] = '{12'hec3, 12'hfca, 12'h624, 12'h502,
    12'h428, 12'h303, 12'h231, 12'h159, 12'h800, 12'h912, 12'ha10,
    12'hb00, 12'hc12, 12'h059};
  logic [11:0] exp_tab [7] = '{12'h000, 12'h100, 12'h212, 12'h304,
    12'h429, 12'h502, 12'h624};

  // pull-up on the shared data line.
  assign sda_line = ~(host_low | sda_oe);
  always #25 ref_clk_i = ~ref_clk_i;
  always #50 if (xtal_run) xtal = ~xtal;

  srtc_top #(.DEV_ADDR(DEV)) u_srtc_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ser_clk_i(scl), .ser_data_i(sda_line), .ser_data_o(),
    .ser_data_oe_o(sda_oe), .crystal_in_i(xtal), .crystal_out_o(),
    .sub_clock_gate_in_i(gate), .sub_clock_out_o(sub_clk),
    .supply_below_high_i(sup_hi), .supply_below_low_i(sup_lo),
    .irq_out_daily_periodic_o(), .irq_out_daily_periodic_oe_o(irq_a),
    .irq_out_weekly_o(), .irq_out_weekly_oe_o(irq_b));

  srtc_host_model u_srtc_host_model (
    .line_i(sda_line), .scl_o(scl), .pull_low_o(host_low));

  task automatic bad(input string m);
    err_count++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
    input string m);
    num_checks++;
    if (g !== e)
      bad($sformatf("%s got %h want %h", m, g, e));
  endtask

  task automatic chk1(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1)
      bad(m);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic count_rises(output int c);
    logic p;
    c = 0;
    repeat (6) @(posedge ref_clk_i);
    p = sub_clk;
    repeat (40)
    begin
      @(posedge ref_clk_i);
      #1 if (sub_clk === 1'b1 && p === 1'b0)
        c++;
      p = sub_clk;
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rst_tab[i])
    begin
      rd(rst_tab[i][11:8], rv);
      chk8(rv, rst_tab[i][7:0], "reset value");
    end
    rd(4'hf, rv);
    chk1(rv[4], "power-on flag");
    wr(4'hd, 8'h5a);
    rd(4'hd, rv);
    chk8(rv, 8'h00, "unmapped index");
    $display("test reset done");

    repeat (2100) @(posedge ref_clk_i);
    rd(4'hf, rv);
    chk1(rv[3], "oscillator halt flag");
    xtal_run <= 1'b1;
    repeat (200) @(posedge ref_clk_i);
    // host clears status before trusting time
    wr(4'hf, 8'h00);
    repeat (200) @(posedge ref_clk_i);
    rd(4'hf, rv);
    chk8(rv, 8'h00, "status after clear");
    $display("test status done");

    gate <= 1'b1;
    count_rises(n);
    chk1(n >= 19 && n <= 21, "clock output rate");
    wr(4'he, 8'h30);
    count_rises(n);
    chk1(n == 0, "clock output disabled");
    wr(4'he, 8'h20);
    gate <= 1'b0;
    count_rises(n);
    chk1(n == 0, "clock output gated");
    $display("test clock output done");

    sup_hi <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    rd(4'hf, rv);
    chk1(!rv[5], "drop flag on unselected level");
    sup_lo <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    sup_lo <= 1'b0;
    sup_hi <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rd(4'hf, rv);
    chk1(rv[5], "drop flag latched low level");
    wr(4'hf, 8'h40);
    rd(4'hf, rv);
    chk1(!rv[5], "drop flag cleared");
    sup_hi <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    rd(4'hf, rv);
    chk1(rv[5], "drop flag high level");
    sup_hi <= 1'b0;
    $display("test supply done");

    u_srtc_host_model.wr_frame(DEV, 4'h8, 8'h45, ok);
    chk1(ok, "serial write ack");
    rd(4'h8, rv);
    chk8(rv, 8'h45, "serial write data");
    u_srtc_host_model.rd_frame(DEV, 4'h8, rv, ok);
    chk1(ok, "serial read ack");
    chk8(rv, 8'h45, "serial read data");
    u_srtc_host_model.wr_frame(DEV ^ 7'h01, 4'h8, 8'h11, ok);
    chk1(!ok, "foreign address acked");
    rd(4'h8, rv);
    chk8(rv, 8'h45, "foreign write landed");
    $display("test serial done");

    foreach (set_tab[i])
      wr(set_tab[i][11:8], set_tab[i][7:0]);
    for (n = 0; n < 80000 && irq_b !== 1'b1; n++)
      @(posedge ref_clk_i) #1;
    if (n == 80000)
    begin
      bad("no alarm within bound");
      give_verdict;
    end
    repeat (2) @(posedge ref_clk_i);
    foreach (exp_tab[i])
    begin
      rd(exp_tab[i][11:8], rv);
      chk8(rv, exp_tab[i][7:0], "after tick");
    end
    rd(4'hf, rv);
    chk8(rv & 8'h07, 8'h07, "event flags");
    chk1(irq_a, "first interrupt pin");
    chk1(irq_b, "second interrupt pin");
    wr(4'he, 8'h8b);
    repeat (2) @(posedge ref_clk_i);
    chk1(!irq_a && irq_b, "periodic halt");
    wr(4'hf, 8'h00);
    repeat (3) @(posedge ref_clk_i);
    chk1(!irq_a && !irq_b, "interrupts after clear");
    $display("test calendar done");
    give_verdict;
  end
endmodule
